// ==== rtl/tfes_event_status.sv ====
// T1 framer event status register bank with alarms, timer and bus slave
`timescale 1ns/100ps
module tfes_event_status
    import tfes_pkg::*;
#(
    parameter int SIG_BITS = 96,
    parameter int TICK_SHORT = TICK_SHORT_CYC,
    parameter int TICK_LONG = TICK_LONG_CYC
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // Avalon-MM slave
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Line side events and data
    input wire logic rclk_pin,
    input wire tfes_line_ev_s line_ev,
    input wire tfes_bit_s rx_link_bit,
    input wire tfes_bit_s rx_line_bit,
    input wire logic [SIG_BITS-1:0] rx_sig_bits,
    input wire logic rx_sig_valid,
    input wire logic frame_sync_loss,
    // Interrupt and alarm levels
    output logic irq,
    output logic carrier_loss,
    output logic all_ones_alarm
);
    logic [7:0] status_r;
    logic [7:0] mask_r;
    logic [7:0] pattern_a_r;
    logic [7:0] pattern_b_r;
    logic [7:0] ev_set;
    logic ack_r;
    logic take;
    logic rd_take;
    logic [6:0] idx;
    logic rclk_level;
    logic rclk_rise;
    logic [31:0] tick_cnt_r;
    logic [1:0] tick_phase_r;
    logic tick_pulse;
    logic [31:0] tick_target;
    logic [7:0] link_buf_r;
    logic [7:0] link_buf_nxt;
    logic [2:0] link_cnt_r;
    logic [3:0] ones_run_r;
    logic link_full;
    logic link_abort;
    logic [SIG_BITS-1:0] sig_prev_r;
    logic sig_seen_r;
    logic sig_chg;
    tfes_cl_e cl_state_r;
    logic [7:0] zero_cnt_r;
    logic [6:0] win_cnt_r;
    logic [6:0] win_ones_r;
    logic [11:0] ais_cnt_r;
    logic [11:0] ais_zeros_r;
    logic [11:0] ais_zeros_nxt;

    // Receive clock pin sampled into the system clock domain
    tfes_pin_sync u_rclk_sync (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .pin(rclk_pin),
        .level(rclk_level),
        .rise(rclk_rise)
    );

    // Bus handshake: first cycle takes the request, second releases it
    assign take = (avs_read | avs_write) & ~ack_r;
    assign rd_take = avs_read & ~ack_r;
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
    assign idx = avs_address[ADDR_W-1:2];

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= take;
        end
    end

    // Read data is latched when taken, so a later clear cannot alter it
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            avs_readdata <= 32'h0;
        end else if (rd_take) begin
            unique case (idx)
                IDX_EVENT_STATUS_TWO: avs_readdata <= {24'h0, status_r};
                IDX_INTERRUPT_MASK_TWO: avs_readdata <= {24'h0, mask_r};
                IDX_MATCH_PATTERN_A: avs_readdata <= {24'h0, pattern_a_r};
                IDX_MATCH_PATTERN_B: avs_readdata <= {24'h0, pattern_b_r};
                IDX_ALARM_STATUS: begin
                    avs_readdata <= {29'h0, frame_sync_loss,
                        all_ones_alarm, carrier_loss};
                end
                default: avs_readdata <= 32'h0;
            endcase
        end
    end

    // Writable registers; unmapped writes and missing low lane are ignored
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            mask_r <= MASK_RST;
            pattern_a_r <= PATTERN_RST;
            pattern_b_r <= PATTERN_RST;
        end else if (take && avs_write && avs_byteenable[0]) begin
            if (idx == IDX_INTERRUPT_MASK_TWO) begin
                mask_r <= avs_writedata[7:0];
            end
            if (idx == IDX_MATCH_PATTERN_A) begin
                pattern_a_r <= avs_writedata[7:0];
            end
            if (idx == IDX_MATCH_PATTERN_B) begin
                pattern_b_r <= avs_writedata[7:0];
            end
        end
    end

    // Event vector in status bit layout
    always_comb begin
        ev_set = 8'h00;
        ev_set[BIT_RX_MF] = line_ev.rx_mf;
        ev_set[BIT_TX_MF] = line_ev.tx_mf;
        ev_set[BIT_TICK] = tick_pulse;
        ev_set[BIT_RX_FULL] = link_full;
        ev_set[BIT_TX_EMPTY] = line_ev.tx_buf_empty;
        ev_set[BIT_MATCH] = link_full && (link_buf_nxt == pattern_a_r ||
            link_buf_nxt == pattern_b_r);
        ev_set[BIT_ABORT] = link_abort;
        ev_set[BIT_SIG_CHG] = sig_chg;
    end

    // Sticky flags; a read clears them, but a same-cycle event wins
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            status_r <= STATUS_RST;
        end else if (rd_take && idx == IDX_EVENT_STATUS_TWO) begin
            status_r <= ev_set;
        end else begin
            status_r <= status_r | ev_set;
        end
    end

    // Level interrupt while any unmasked flag is set
    assign irq = |(status_r & mask_r);

    // Tick timer counts receive clock edges; three intervals repeat
    assign tick_target = (tick_phase_r == 2'd2) ? TICK_LONG : TICK_SHORT;
    assign tick_pulse = rclk_rise && (tick_cnt_r == tick_target - 32'd1);

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            tick_cnt_r <= 32'h0;
            tick_phase_r <= 2'd0;
        end else if (tick_pulse) begin
            tick_cnt_r <= 32'h0;
            tick_phase_r <= (tick_phase_r == 2'd2) ? 2'd0 :
                tick_phase_r + 2'd1;
        end else if (rclk_rise) begin
            tick_cnt_r <= tick_cnt_r + 32'd1;
        end
    end

    // Receive link buffer: shift in bits, full every eighth bit
    assign link_buf_nxt = {link_buf_r[6:0], rx_link_bit.value};
    assign link_full = rx_link_bit.valid &&
        (link_cnt_r == 3'(LINK_BUF_BITS - 1));
    assign link_abort = rx_link_bit.valid && rx_link_bit.value &&
        (ones_run_r == 4'(ABORT_ONES - 1));

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            link_buf_r <= 8'h00;
            link_cnt_r <= 3'd0;
        end else if (rx_link_bit.valid) begin
            link_buf_r <= link_buf_nxt;
            link_cnt_r <= link_cnt_r + 3'd1;
        end
    end

    // Run of ones restarts after each abort so a long run flags again
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            ones_run_r <= 4'd0;
        end else if (rx_link_bit.valid) begin
            if (!rx_link_bit.value || link_abort) begin
                ones_run_r <= 4'd0;
            end else begin
                ones_run_r <= ones_run_r + 4'd1;
            end
        end
    end

    // Signaling change; the first sample after reset only primes history
    assign sig_chg = rx_sig_valid && sig_seen_r &&
        (rx_sig_bits != sig_prev_r);

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            sig_prev_r <= '0;
            sig_seen_r <= 1'b0;
        end else if (rx_sig_valid) begin
            sig_prev_r <= rx_sig_bits;
            sig_seen_r <= 1'b1;
        end
    end

    // Carrier loss: declare on zeros, evaluate clearing in fixed windows
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            cl_state_r <= CL_OK;
            zero_cnt_r <= 8'd0;
            win_cnt_r <= 7'd0;
            win_ones_r <= 7'd0;
        end else if (rx_line_bit.valid) begin
            unique case (cl_state_r)
                CL_OK: begin
                    if (rx_line_bit.value) begin
                        zero_cnt_r <= 8'd0;
                    end else if (zero_cnt_r == 8'(CL_DECLARE_ZEROS - 1)) begin
                        cl_state_r <= CL_LOST;
                        zero_cnt_r <= 8'd0;
                    end else begin
                        zero_cnt_r <= zero_cnt_r + 8'd1;
                    end
                end
                CL_LOST: begin
                    if (rx_line_bit.value) begin
                        cl_state_r <= CL_EVAL;
                        win_cnt_r <= 7'd1;
                        win_ones_r <= 7'd1;
                    end
                end
                CL_EVAL: begin
                    if (win_cnt_r == 7'(CL_CLEAR_WINDOW - 1)) begin
                        // Window ends with this bit; failure waits for a one
                        if (win_ones_r + 7'(rx_line_bit.value) >=
                            7'(CL_CLEAR_ONES)) begin
                            cl_state_r <= CL_OK;
                        end else begin
                            cl_state_r <= CL_LOST;
                        end
                    end else begin
                        win_cnt_r <= win_cnt_r + 7'd1;
                        win_ones_r <= win_ones_r + 7'(rx_line_bit.value);
                    end
                end
                default: cl_state_r <= CL_OK;
            endcase
        end
    end

    assign carrier_loss = (cl_state_r != CL_OK);

    // All-ones alarm: a framed signal carries framing zeros in each
    // window, so a small zero allowance still rejects it while errors pass
    // Invert inside a concatenation so only the one bit is inverted
    assign ais_zeros_nxt = ais_zeros_r + {11'h0, ~rx_line_bit.value};

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            ais_cnt_r <= 12'd0;
            ais_zeros_r <= 12'd0;
            all_ones_alarm <= 1'b0;
        end else if (rx_line_bit.valid) begin
            if (ais_cnt_r == 12'(AIS_WINDOW - 1)) begin
                all_ones_alarm <= (ais_zeros_nxt <= 12'(AIS_ZERO_MAX));
                ais_cnt_r <= 12'd0;
                ais_zeros_r <= 12'd0;
            end else begin
                ais_cnt_r <= ais_cnt_r + 12'd1;
                ais_zeros_r <= ais_zeros_nxt;
            end
        end
    end

    // Checks on the status bank and the alarm logic, all on sys_clk
    default clocking chk_cb @(posedge sys_clk);
    endclocking
    default disable iff (!resetn);

    sequence status_read_s;
        rd_take && idx == IDX_EVENT_STATUS_TWO;
    endsequence

    sequence quiet_s;
        !(rd_take && idx == IDX_EVENT_STATUS_TWO);
    endsequence

    rx_mf_flag_a: assert property (
        line_ev.rx_mf |=> status_r[BIT_RX_MF])
        else $error("receive multiframe flag not set");

    tx_mf_flag_a: assert property (
        line_ev.tx_mf |=> status_r[BIT_TX_MF])
        else $error("transmit multiframe flag not set");

    tick_period_a: assert property (
        tick_pulse |=> tick_cnt_r == 32'h0 && status_r[BIT_TICK])
        else $error("tick flag or timer restart missing");

    link_full_a: assert property (
        rx_link_bit.valid && link_cnt_r == 3'd7 |=> status_r[BIT_RX_FULL])
        else $error("receive link full flag not set");

    tx_empty_a: assert property (
        line_ev.tx_buf_empty |=> status_r[BIT_TX_EMPTY])
        else $error("transmit link empty flag not set");

    link_match_a: assert property (
        link_full && link_buf_nxt == pattern_a_r |=> status_r[BIT_MATCH])
        else $error("link match flag not set");

    link_abort_a: assert property (
        rx_link_bit.valid && rx_link_bit.value && ones_run_r == 4'd7
        |=> status_r[BIT_ABORT] && ones_run_r == 4'd0)
        else $error("link abort flag not set");

    sig_change_a: assert property (
        sig_chg |=> status_r[BIT_SIG_CHG])
        else $error("signaling change flag not set");

    eval_start_a: assert property (
        cl_state_r == CL_LOST && rx_line_bit.valid && rx_line_bit.value
        |=> cl_state_r == CL_EVAL && win_cnt_r == 7'd1)
        else $error("carrier clear evaluation did not start");

    carrier_declare_a: assert property (
        cl_state_r == CL_OK && rx_line_bit.valid && !rx_line_bit.value &&
        zero_cnt_r == 8'd191 |=> carrier_loss)
        else $error("carrier loss not declared after zeros");

    // Event to flag to interrupt, so a broken flag path trips it too
    irq_gate_a: assert property (
        line_ev.rx_mf ##1 mask_r[BIT_RX_MF] |-> irq)
        else $error("unmasked flag did not raise interrupt");

    // A clearing read acts one edge later, so the read is checked first
    sticky_a: assert property (
        status_r[BIT_RX_MF] ##0 quiet_s |=> status_r[BIT_RX_MF])
        else $error("status flag dropped without a read");

    read_clear_a: assert property (
        status_read_s ##0 !line_ev.rx_mf |=> !status_r[BIT_RX_MF] ##1 !ack_r)
        else $error("status read did not clear flag");
endmodule

// ==== inc/tfes_pkg.sv ====
// Shared constants and carrier types of the T1 framer event status block
package tfes_pkg;
    // Register indices; byte address is four times the index
    localparam logic [6:0] IDX_EVENT_STATUS_TWO = 7'h21;
    localparam logic [6:0] IDX_INTERRUPT_MASK_TWO = 7'h6f;
    localparam logic [6:0] IDX_ALARM_STATUS = 7'h30;
    localparam logic [6:0] IDX_MATCH_PATTERN_A = 7'h31;
    localparam logic [6:0] IDX_MATCH_PATTERN_B = 7'h32;
    localparam int ADDR_W = 9;

    // Bit positions of event_status_two and interrupt_mask_two
    localparam int BIT_RX_MF = 7;
    localparam int BIT_TX_MF = 6;
    localparam int BIT_TICK = 5;
    localparam int BIT_RX_FULL = 4;
    localparam int BIT_TX_EMPTY = 3;
    localparam int BIT_MATCH = 2;
    localparam int BIT_ABORT = 1;
    localparam int BIT_SIG_CHG = 0;

    // Bit positions of the alarm status register
    localparam int BIT_CARRIER_LOSS = 0;
    localparam int BIT_ALL_ONES = 1;
    localparam int BIT_SYNC_LOSS = 2;

    // Reset values
    localparam logic [7:0] STATUS_RST = 8'h00;
    localparam logic [7:0] MASK_RST = 8'h00;
    localparam logic [7:0] PATTERN_RST = 8'h00;

    // Link data buffer and abort figures
    localparam int LINK_BUF_BITS = 8;
    localparam int ABORT_ONES = 8;

    // Carrier loss figures, in received bits
    localparam int CL_DECLARE_ZEROS = 192;
    localparam int CL_CLEAR_ONES = 14;
    localparam int CL_CLEAR_WINDOW = 112;

    // All-ones alarm: zeros tolerated per window of received bits
    localparam int AIS_WINDOW = 3088;
    localparam int AIS_ZERO_MAX = 6;

    // Tick timer: receive clock rate and interval lengths
    localparam longint RCLK_HZ = 64'd1544000;
    localparam longint TICK_SHORT_MS = 64'd999;
    localparam longint TICK_LONG_MS = 64'd1002;
    localparam int TICK_SHORT_CYC = int'(RCLK_HZ * TICK_SHORT_MS / 64'd1000);
    localparam int TICK_LONG_CYC = int'(RCLK_HZ * TICK_LONG_MS / 64'd1000);

    // Carrier loss states
    typedef enum logic [2:0] {
        CL_OK = 3'b001,
        CL_LOST = 3'b010,
        CL_EVAL = 3'b100
    } tfes_cl_e;

    // Framing boundary and buffer events, one-cycle pulses
    typedef struct packed {
        logic rx_mf;
        logic tx_mf;
        logic tx_buf_empty;
    } tfes_line_ev_s;

    // One received bit with its strobe
    typedef struct packed {
        logic valid;
        logic value;
    } tfes_bit_s;
endpackage

// ==== rtl/tfes_pin_sync.sv ====
// Three-stage pin synchroniser with filtered level and rising-edge pulse
`timescale 1ns/100ps
module tfes_pin_sync (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // Pin side
    input wire logic pin,
    // Synchronised side
    output logic level,
    output logic rise
);
    logic s1_r;
    logic s2_r;
    logic s3_r;

    // Only s2 reads s1; a change counts once s2 and s3 agree
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
        end else begin
            s1_r <= pin;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // Filtered level and its rising-edge pulse
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            level <= 1'b0;
            rise <= 1'b0;
        end else begin
            rise <= 1'b0;
            if (s2_r == s3_r) begin
                level <= s3_r;
                rise <= s3_r & ~level;
            end
        end
    end
endmodule

// ==== dv/tfes_line_model.sv ====
// Line side model: framing events, link and line bits, receive clock
`timescale 1ns/100ps
module tfes_line_model
    import tfes_pkg::*;
#(
    parameter int SIG_BITS = 96
) (
    // Clock
    input wire logic sys_clk,
    // Line side drive
    output logic rclk_pin,
    output tfes_line_ev_s line_ev,
    output tfes_bit_s rx_link_bit,
    output tfes_bit_s rx_line_bit,
    output logic [SIG_BITS-1:0] rx_sig_bits,
    output logic rx_sig_valid,
    output logic frame_sync_loss
);
    // Quiet line at time zero
    initial begin
        rclk_pin = 1'b0;
        line_ev = '0;
        rx_link_bit = '0;
        rx_line_bit = '0;
        rx_sig_bits = '0;
        rx_sig_valid = 1'b0;
        frame_sync_loss = 1'b0;
    end

    // One-cycle framing or buffer event
    task automatic ev(input tfes_line_ev_s e);
        line_ev <= e;
        @(posedge sys_clk);
        line_ev <= '0;
        @(posedge sys_clk);
    endtask

    // Link byte, MSB first; idle value flips so a stale bit never helps
    task automatic link_byte(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            rx_link_bit <= '{1'b1, b[i]};
            @(posedge sys_clk);
        end
        rx_link_bit <= '{1'b0, ~b[0]};
        @(posedge sys_clk);
    endtask

    // Run of n line bits of v, inverted every per bits when per is set
    task automatic line_run(input int n, input logic v, input int per);
        for (int i = 0; i < n; i++) begin
            rx_line_bit <= '{1'b1, (per != 0 && i % per == 0) ? ~v : v};
            @(posedge sys_clk);
        end
        rx_line_bit <= '{1'b0, ~v};
        @(posedge sys_clk);
    endtask

    // Signaling snapshot; bits go stale once the strobe drops
    task automatic sig(input logic [SIG_BITS-1:0] v);
        rx_sig_bits <= v;
        rx_sig_valid <= 1'b1;
        @(posedge sys_clk);
        rx_sig_valid <= 1'b0;
        rx_sig_bits <= ~v;
        @(posedge sys_clk);
    endtask

    // Receive clock edges, slow enough for the pin synchroniser
    task automatic rclk_edges(input int n);
        for (int i = 0; i < n; i++) begin
            rclk_pin <= 1'b1;
            repeat (4) @(posedge sys_clk);
            rclk_pin <= 1'b0;
            repeat (4) @(posedge sys_clk);
        end
    endtask

    // Frame sync loss level
    task automatic set_sync(input logic v);
        frame_sync_loss <= v;
        @(posedge sys_clk);
    endtask
endmodule

// ==== dv/tfes_tb.sv ====
// Self-checking bench for the event status block
`timescale 1ns/100ps
module tb
    import tfes_pkg::*;
;
    localparam int TS = 5;
    localparam int TL = 7;
    localparam int SB = 96;
    localparam logic [8:0] A_ST = {IDX_EVENT_STATUS_TWO, 2'b00};
    localparam logic [8:0] A_MK = {IDX_INTERRUPT_MASK_TWO, 2'b00};
    localparam logic [8:0] A_AL = {IDX_ALARM_STATUS, 2'b00};
    localparam logic [8:0] A_PA = {IDX_MATCH_PATTERN_A, 2'b00};
    localparam logic [8:0] A_PB = {IDX_MATCH_PATTERN_B, 2'b00};
    localparam logic [8:0] A_NO = 9'h100;

    // Bus and line signals
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic [8:0] avs_address = '0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = '0;
    logic [3:0] avs_byteenable = '0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic rclk_pin;
    tfes_line_ev_s line_ev;
    tfes_bit_s rx_link_bit;
    tfes_bit_s rx_line_bit;
    logic [SB-1:0] rx_sig_bits;
    logic rx_sig_valid;
    logic frame_sync_loss;
    logic irq;
    logic carrier_loss;
    logic all_ones_alarm;
    int n_errors = 0;
    int check_count = 0;

    // 10 MHz clock
    initial begin
        forever #50 sys_clk = ~sys_clk;
    end

    // Short tick counts keep the timer test brief
    tfes_event_status #(.SIG_BITS(SB), .TICK_SHORT(TS), .TICK_LONG(TL))
    u_dut (
        .sys_clk(sys_clk), .resetn(resetn),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .rclk_pin(rclk_pin),
        .line_ev(line_ev), .rx_link_bit(rx_link_bit),
        .rx_line_bit(rx_line_bit), .rx_sig_bits(rx_sig_bits),
        .rx_sig_valid(rx_sig_valid), .frame_sync_loss(frame_sync_loss),
        .irq(irq), .carrier_loss(carrier_loss),
        .all_ones_alarm(all_ones_alarm)
    );

    tfes_line_model #(.SIG_BITS(SB)) u_line (
        .sys_clk(sys_clk), .rclk_pin(rclk_pin), .line_ev(line_ev),
        .rx_link_bit(rx_link_bit), .rx_line_bit(rx_line_bit),
        .rx_sig_bits(rx_sig_bits), .rx_sig_valid(rx_sig_valid),
        .frame_sync_loss(frame_sync_loss)
    );

    // Verdict and end of run
    task automatic conclude();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    // One Avalon transfer; request held until waitrequest is seen low
    task automatic bus(input logic w, input logic [8:0] a,
                       input logic [7:0] d, input logic [3:0] be,
                       output logic [31:0] q);
        int n;
        n = 0;
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        avs_byteenable <= be;
        avs_write <= w;
        avs_read <= ~w;
        do begin
            @(posedge sys_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (avs_waitrequest !== 1'b0) begin
            n_errors++;
            conclude();
        end else begin
            q = avs_readdata;
            avs_write <= 1'b0;
            avs_read <= 1'b0;
            @(posedge sys_clk);
        end
    endtask

    task automatic wr(input logic [8:0] a, input logic [7:0] d,
                      input logic [3:0] be);
        logic [31:0] q;
        bus(1'b1, a, d, be, q);
    endtask

    task automatic rchk(input string nm, input logic [8:0] a,
                        input logic [7:0] e);
        logic [31:0] q;
        bus(1'b0, a, 8'h00, 4'hf, q);
        chk(nm, {24'h0, e}, q);
    endtask

    // Main sequence
    initial begin
        tfes_line_ev_s evs[3];
        logic [7:0] evb[3];
        logic [7:0] pat[4];
        logic [7:0] lexp[4];
        int gap[3];
        evs = '{3'h4, 3'h2, 3'h1};
        evb = '{8'h80, 8'h40, 8'h08};
        pat = '{8'ha5, 8'h5a, 8'h3c, 8'hff};
        lexp = '{8'h14, 8'h14, 8'h10, 8'h12};
        gap = '{TS, TS, TL};
        repeat (20) @(posedge sys_clk);
        resetn <= 1'b1;
        @(posedge sys_clk);
        // Reset values, read-only status, unmapped place
        rchk("status", A_ST, STATUS_RST);
        rchk("mask", A_MK, MASK_RST);
        rchk("pattern a", A_PA, PATTERN_RST);
        wr(A_ST, 8'hff, 4'h1);
        rchk("status ro", A_ST, 8'h00);
        wr(A_NO, 8'hff, 4'h1);
        rchk("unmapped", A_NO, 8'h00);
        // Each framing or buffer event reaches irq through its own mask bit only
        for (int k = 0; k < 3; k++) begin
            wr(A_MK, evb[k], 4'h1);
            u_line.ev(evs[k]);
            chk("irq on", 32'(irq), 32'h1);
            rchk("event", A_ST, evb[k]);
            chk("irq off", 32'(irq), 32'h0);
            rchk("cleared", A_ST, 8'h00);
        end
        // Masked flag stays silent but still sticks
        wr(A_MK, 8'h40, 4'h1);
        u_line.ev(evs[0]);
        repeat (10) @(posedge sys_clk);
        chk("irq masked", 32'(irq), 32'h0);
        rchk("sticky", A_ST, 8'h80);
        wr(A_MK, 8'hff, 4'h0);
        rchk("mask be", A_MK, 8'h40);
        // Link buffer: full, both patterns, abort on eight ones
        wr(A_PA, 8'ha5, 4'h1);
        wr(A_PB, 8'h5a, 4'h1);
        rchk("pattern b", A_PB, 8'h5a);
        for (int k = 0; k < 4; k++) begin
            u_line.link_byte(pat[k]);
            rchk("link", A_ST, lexp[k]);
        end
        // Signaling change; the first snapshot only primes
        u_line.sig('0);
        rchk("sig prime", A_ST, 8'h00);
        u_line.sig({1'b1, {(SB-1){1'b0}}});
        rchk("sig change", A_ST, 8'h01);
        u_line.sig({1'b1, {(SB-1){1'b0}}});
        rchk("sig same", A_ST, 8'h00);
        // Tick intervals short, short, long
        for (int k = 0; k < 3; k++) begin
            u_line.rclk_edges(gap[k] - 1);
            rchk("tick early", A_ST, 8'h00);
            u_line.rclk_edges(1);
            rchk("tick", A_ST, 8'h20);
        end
        // Carrier loss declare at 192 zeros, clear at 14 ones in 112
        u_line.line_run(CL_DECLARE_ZEROS - 1, 1'b0, 0);
        repeat (3) @(posedge sys_clk);
        chk("cl early", 32'(carrier_loss), 32'h0);
        u_line.line_run(1, 1'b0, 0);
        repeat (3) @(posedge sys_clk);
        chk("cl set", 32'(carrier_loss), 32'h1);
        rchk("alarm cl", A_AL, 8'h01);
        u_line.line_run(1, 1'b1, 0);
        u_line.line_run(CL_CLEAR_WINDOW - 1, 1'b0, 0);
        // The clear is judged when the 112-bit window closes
        u_line.line_run(CL_CLEAR_ONES, 1'b1, 0);
        u_line.line_run(CL_CLEAR_WINDOW - CL_CLEAR_ONES - 1, 1'b0, 0);
        repeat (3) @(posedge sys_clk);
        chk("cl hold", 32'(carrier_loss), 32'h1);
        u_line.line_run(1, 1'b0, 0);
        repeat (3) @(posedge sys_clk);
        chk("cl clear", 32'(carrier_loss), 32'h0);
        // Framed ones carry too many zeros; sparse errors still alarm
        u_line.line_run(3 * AIS_WINDOW, 1'b1, AIS_WINDOW / 8);
        chk("framed ones", 32'(all_ones_alarm), 32'h0);
        u_line.line_run(3 * AIS_WINDOW, 1'b1, 1000);
        chk("all ones", 32'(all_ones_alarm), 32'h1);
        // Software reads sync loss beside the all-ones alarm
        u_line.set_sync(1'b1);
        rchk("alarm qual", A_AL, 8'h06);
        conclude();
    end
endmodule
